// ### design/dbp_duty_latch.sv
// Active duty latch: second stage of the duty double buffer
`timescale 1ns/10ps
module dbp_duty_latch
    import dbp_pkg::*;
#(
    parameter int DUTY_W = DBP_DUTY_W     // Duty value width
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_clk_en,
    input  wire logic              i_load,
    input  wire logic [DUTY_W-1:0] i_buf_duty,
    output logic      [DUTY_W-1:0] o_act_duty
);

    // Loads only on period match; no software path reaches it
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_act_duty <= '0;
        end else if (i_clk_en && i_load) begin
            o_act_duty <= i_buf_duty;
        end
    end

endmodule

// ### design/dbp_pkg.sv
// Shared constants, types and helpers of the double buffered PWM stage
package dbp_pkg;

    // Widths of the counters and duty values
    localparam int DBP_TMR_W      = 8;    // Period timer count width
    localparam int DBP_DUTY_W     = 10;   // Full duty value width
    localparam int DBP_FRAC_W     = 2;    // Low duty bits / phase bits
    localparam int DBP_PRE_W      = 6;    // Prescaler sub-count width

    // Oscillator timing: one system clock is one oscillator period
    localparam int DBP_OSC_PERIOD_NS = 40;  // Oscillator period in ns
    localparam int DBP_QUARTERS      = 4;   // Oscillator periods a cycle

    // Field positions in compare_unit_control
    localparam int DBP_CTRL_DLO_LSB = 4;    // Duty low bits <5:4>
    localparam int DBP_CTRL_SEL_LSB = 2;    // Mode bits <3:2>
    localparam logic [1:0] DBP_MODE_PWM = 2'h3;  // Mode <3:2> for PWM

    // Reset values
    localparam logic [7:0] DBP_CTRL_RST   = 8'h00;
    localparam logic [7:0] DBP_DUTY_RST   = 8'h00;
    localparam logic [7:0] DBP_PERIOD_RST = 8'hFF;

    // Prescaler selections
    localparam logic [1:0] DBP_PRE_1  = 2'h0;  // Divide by 1
    localparam logic [1:0] DBP_PRE_4  = 2'h1;  // Divide by 4

    // Output latch states, Gray coded along off, low, high
    typedef enum logic [1:0] {
        DBP_OFF  = 2'h0,
        DBP_LOW  = 2'h1,
        DBP_HIGH = 2'h3
    } dbp_out_st_t;

    // Prescale factor chosen by the select bits
    function automatic int dbp_pre_factor(input logic [1:0] sel);
        int f;
        case (sel)
            DBP_PRE_1: f = 1;
            DBP_PRE_4: f = 4;
            default:   f = 16;
        endcase
        return f;
    endfunction

    // Oscillator periods in one whole timer increment
    function automatic int dbp_inc_len(input logic [1:0] sel);
        return DBP_QUARTERS * dbp_pre_factor(sel);
    endfunction

endpackage

// ### design/dbp_pwm_top.sv
// Double buffered PWM output stage of a capture/compare unit
`timescale 1ns/10ps
module dbp_pwm_top
    import dbp_pkg::*;
(
    input  wire logic       i_sys_clk,               // Oscillator clock
    input  wire logic       i_rst_n,                 // Async reset
    input  wire logic       i_clk_en,                // Freezes all state
    input  wire logic       i_ctrl_wr,               // Control write
    input  wire logic [7:0] i_ctrl_data,             // Control data
    input  wire logic       i_duty_wr,               // Duty buffer write
    input  wire logic [7:0] i_duty_data,             // Duty buffer data
    input  wire logic       i_period_wr,             // Period write
    input  wire logic [7:0] i_period_data,           // Period data
    input  wire logic       i_timer_on,              // Period timer run
    input  wire logic [1:0] i_prescale_sel,          // Prescale select
    input  wire logic       i_shared_port_direction, // 1 = pin input
    input  wire logic       i_shared_io_port_latch,  // Port data latch
    output logic            o_pwm_output_pin,        // Pin drive value
    output logic            o_pwm_output_pin_oe,     // Pin drive enable
    output logic [7:0]      o_compare_unit_control,  // Control readback
    output logic [7:0]      o_duty_buffer_register,  // Buffer readback
    output logic [7:0]      o_period_register,       // Period readback
    output logic [7:0]      o_period_timer_count,    // Timer readback
    output logic [7:0]      o_active_duty_latch      // Active duty, RO
);

    logic [7:0]   ctrl_ff;        // Control register
    logic [7:0]   duty_buf_ff;    // Duty buffer register
    logic [7:0]   period_ff;      // Period register
    logic         pin_ff;         // Registered pin value
    logic         oe_ff;          // Registered pin enable
    dbp_out_st_t  out_st_ff;      // PWM output latch state
    dbp_out_st_t  nxt_out_st;     // Next output latch state
    logic         pwm_mode;       // Control selects PWM
    logic [9:0]   buf_duty;       // Buffered 10-bit duty
    logic [9:0]   act_duty;       // Active 10-bit duty
    logic         ext_hit;        // Duty meets extended count

    dbp_tb_if     tb ();          // Timebase signals

    // Period timer and phase counter
    dbp_timebase #(
        .PRE_W          (DBP_PRE_W)
    ) u_timebase (
        .i_sys_clk      (i_sys_clk),
        .i_rst_n        (i_rst_n),
        .i_clk_en       (i_clk_en),
        .i_timer_on     (i_timer_on),
        .i_prescale_sel (i_prescale_sel),
        .i_period       (period_ff),
        .tb             (tb.src)
    );

    // Active duty stage of the double buffer
    dbp_duty_latch #(
        .DUTY_W         (DBP_DUTY_W)
    ) u_duty_latch (
        .i_sys_clk      (i_sys_clk),
        .i_rst_n        (i_rst_n),
        .i_clk_en       (i_clk_en),
        .i_load         (tb.match && pwm_mode),
        .i_buf_duty     (buf_duty),
        .o_act_duty     (act_duty)
    );

    // Mode decode and duty assembly
    always_comb begin
        pwm_mode = ctrl_ff[DBP_CTRL_SEL_LSB +: 2] == DBP_MODE_PWM;
        buf_duty = {duty_buf_ff,
                    ctrl_ff[DBP_CTRL_DLO_LSB +: DBP_FRAC_W]};
        ext_hit  = tb.nxt_ext == act_duty;
    end

    // Control register, written whole
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_ff <= DBP_CTRL_RST;
        end else if (i_clk_en && i_ctrl_wr) begin
            ctrl_ff <= i_ctrl_data;
        end
    end

    // Duty buffer, writable at any time
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            duty_buf_ff <= DBP_DUTY_RST;
        end else if (i_clk_en && i_duty_wr) begin
            duty_buf_ff <= i_duty_data;
        end
    end

    // Period register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_ff <= DBP_PERIOD_RST;
        end else if (i_clk_en && i_period_wr) begin
            period_ff <= i_period_data;
        end
    end

    // Output latch next state
    always_comb begin
        nxt_out_st = out_st_ff;
        case (out_st_ff)
            DBP_OFF: begin
                // Entering PWM: high at once on a match with nonzero duty, else wait low for the next period start
                if (pwm_mode && tb.match && buf_duty != 10'h000) begin
                    nxt_out_st = DBP_HIGH;
                end else if (pwm_mode) begin
                    nxt_out_st = DBP_LOW;
                end
            end
            DBP_LOW: begin
                if (!pwm_mode) begin
                    nxt_out_st = DBP_OFF;
                end else if (tb.match && buf_duty != 10'h000) begin
                    nxt_out_st = DBP_HIGH;
                end
            end
            DBP_HIGH: begin
                if (!pwm_mode) begin
                    nxt_out_st = DBP_OFF;
                end else if (tb.match) begin
                    // Period start: zero duty takes the pin low
                    nxt_out_st = (buf_duty != 10'h000) ?
                                 DBP_HIGH : DBP_LOW;
                end else if (ext_hit) begin
                    nxt_out_st = DBP_LOW;
                end
                // No hit within the period leaves it high
            end
            default: begin
                nxt_out_st = DBP_OFF;
            end
        endcase
    end

    // Output latch state
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_st_ff <= DBP_OFF;
        end else if (i_clk_en) begin
            out_st_ff <= nxt_out_st;
        end
    end

    // Pin value: PWM latch in PWM mode, else the port data latch
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_ff <= 1'b0;
        end else if (i_clk_en) begin
            pin_ff <= pwm_mode ? (nxt_out_st == DBP_HIGH)
                               : i_shared_io_port_latch;
        end
    end

    // Pin enable follows the shared direction bit
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_ff <= 1'b0;
        end else if (i_clk_en) begin
            oe_ff <= !i_shared_port_direction;
        end
    end

    // Outputs, all from flops
    assign o_pwm_output_pin       = pin_ff;
    assign o_pwm_output_pin_oe    = oe_ff;
    assign o_compare_unit_control = ctrl_ff;
    assign o_duty_buffer_register = duty_buf_ff;
    assign o_period_register      = period_ff;
    assign o_period_timer_count   = tb.count;
    assign o_active_duty_latch    = act_duty[9:2];

    // Checking helpers: settings unchanged since the last match
    logic        seen_ff;     // A full period with stable settings
    logic [15:0] per_cnt_ff;  // Enabled cycles since last match
    logic [15:0] hi_cnt_ff;   // Enabled cycles spent high
    logic [1:0]  sel_ff;      // Prescale select one cycle ago

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_ff    <= 1'b0;
            per_cnt_ff <= 16'h0000;
            hi_cnt_ff  <= 16'h0000;
            sel_ff     <= 2'h0;
        end else if (i_clk_en) begin
            sel_ff     <= i_prescale_sel;
            per_cnt_ff <= tb.match ? 16'h0000 : per_cnt_ff + 16'h0001;
            hi_cnt_ff  <= (out_st_ff != DBP_HIGH || tb.match) ?
                          16'h0000 : hi_cnt_ff + 16'h0001;
            if (i_period_wr || !i_timer_on ||
                i_prescale_sel != sel_ff || !pwm_mode) begin
                seen_ff <= 1'b0;
            end else if (tb.match) begin
                seen_ff <= 1'b1;
            end
        end
    end

    chk_zero_ctrl_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && i_ctrl_wr && i_ctrl_data == 8'h00)
        |=> ##1 (out_st_ff == DBP_OFF || !i_clk_en))
        else $error("control zero did not force the output low");

    chk_period_len: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && tb.match && seen_ff && !i_period_wr &&
         i_prescale_sel == sel_ff)
        |-> (int'(per_cnt_ff) == (int'(period_ff) + 1) *
             dbp_inc_len(i_prescale_sel) - 1))
        else $error("PWM period length wrong");

    chk_timer_clear: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && tb.match)
        |-> (tb.count == period_ff) ##1 (tb.count == 8'h00))
        else $error("timer not cleared after period match");

    chk_set_on_match: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && tb.match && pwm_mode)
        |=> (o_pwm_output_pin == ($past(buf_duty) != 10'h000)))
        else $error("output wrong at period start");

    chk_duty_load: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && tb.match && pwm_mode)
        |=> (act_duty == $past(buf_duty)))
        else $error("active duty not loaded on match");

    chk_duty_hold: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !(i_clk_en && tb.match && pwm_mode) |=> $stable(act_duty))
        else $error("active duty changed outside a match");

    chk_high_time: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && seen_ff && out_st_ff == DBP_HIGH &&
         nxt_out_st == DBP_LOW && !tb.match)
        |-> (int'(hi_cnt_ff) + 1 ==
             int'(act_duty) * dbp_pre_factor(i_prescale_sel)))
        else $error("PWM high time wrong");

    chk_over_range: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && pwm_mode && out_st_ff == DBP_HIGH && !tb.match &&
         act_duty > {period_ff, 2'h3})
        |=> (out_st_ff == DBP_HIGH))
        else $error("output fell with an unreachable duty");

    chk_pin_mirror: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ($past(i_clk_en) && $past(pwm_mode))
        |-> (o_pwm_output_pin == (out_st_ff == DBP_HIGH)))
        else $error("pin does not follow the PWM latch");

    chk_port_mirror: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ($past(i_rst_n) && $past(i_clk_en) && !$past(pwm_mode))
        |-> (o_pwm_output_pin == $past(i_shared_io_port_latch)))
        else $error("pin does not follow the port latch");

    chk_oe_follow: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ($past(i_rst_n) && $past(i_clk_en))
        |-> (o_pwm_output_pin_oe == !$past(i_shared_port_direction)))
        else $error("pin enable does not follow direction");

    chk_rise_on_match: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ($rose(o_pwm_output_pin) && $past(pwm_mode))
        |-> $past(tb.match))
        else $error("output rose outside a period match");

    chk_count_range: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (seen_ff && pwm_mode) |-> (tb.count <= period_ff))
        else $error("timer ran past the period");

endmodule

// ### design/dbp_tb_if.sv
// Timebase signals passed from the period timer to the output stage
`timescale 1ns/10ps
interface dbp_tb_if;
    logic                      match;    // Period match increment cycle
    logic [7:0]                count;    // Period timer count (flop)
    logic [9:0]                nxt_ext;  // Next extended count
    modport src (output match, output count, output nxt_ext);
    modport snk (input match, input count, input nxt_ext);
endinterface

// ### design/dbp_timebase.sv
// Period timer with prescaler and quarter-cycle phase counter
`timescale 1ns/10ps
module dbp_timebase
    import dbp_pkg::*;
#(
    parameter int PRE_W = DBP_PRE_W       // Sub-count width
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_clk_en,
    input  wire logic       i_timer_on,
    input  wire logic [1:0] i_prescale_sel,
    input  wire logic [7:0] i_period,
    dbp_tb_if.src           tb
);

    logic [PRE_W-1:0] sub_ff;      // Phase and prescaler count
    logic [PRE_W-1:0] nxt_sub;     // Next sub-count
    logic [PRE_W-1:0] term;        // Last sub-count of an increment
    logic [7:0]       tmr_ff;      // Period timer count
    logic [7:0]       nxt_tmr;     // Next timer count
    logic             tick;        // Timer increment cycle
    logic             match;       // Count equals period at increment

    // Two low bits of the extended count: phase or prescaler bits
    function automatic logic [1:0] frac(input logic [PRE_W-1:0] s,
                                        input logic [1:0] sel);
        logic [1:0] f;
        case (sel)
            DBP_PRE_1: f = s[1:0];
            DBP_PRE_4: f = s[3:2];
            default:   f = s[5:4];
        endcase
        return f;
    endfunction

    // Increment and match decode; no postscaler in the path
    always_comb begin
        term    = PRE_W'(dbp_inc_len(i_prescale_sel) - 1);
        tick    = i_timer_on && (sub_ff >= term);
        match   = tick && (tmr_ff == i_period);
        nxt_sub = !i_timer_on ? sub_ff :
                  tick ? '0 : sub_ff + 1'b1;
        nxt_tmr = match ? 8'h00 :
                  tick ? tmr_ff + 8'h01 : tmr_ff;
    end

    // Counter state
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sub_ff <= '0;
            tmr_ff <= 8'h00;
        end else if (i_clk_en) begin
            sub_ff <= nxt_sub;
            tmr_ff <= nxt_tmr;
        end
    end

    // Export to the output stage
    assign tb.match   = match;
    assign tb.count   = tmr_ff;
    assign tb.nxt_ext = {nxt_tmr, frac(nxt_sub, i_prescale_sel)};

endmodule

// ### verification/dbp_load_model.sv
// Pin load model: pull-down load that times pulse high and period
`timescale 1ns/10ps
module dbp_load_model (
    input  wire logic        i_sys_clk,  // Sampling clock
    input  wire logic        i_rst_n,    // Async reset, active low
    input  wire logic        i_pin,      // Pin drive value
    input  wire logic        i_pin_oe,   // Pin drive enable
    output logic             o_line,     // Level seen on the wire
    output logic      [31:0] o_period,   // Last rise to rise time
    output logic      [31:0] o_high      // Last rise to fall time
);
    logic        line_ff;  // Wire level one cycle ago
    logic [31:0] now_ff;   // Free running cycle stamp
    logic [31:0] rise_ff;  // Stamp of the last rising edge

    // Released pin is pulled low, so no stale level survives
    assign o_line = i_pin_oe ? i_pin : 1'b0;

    // Stamps wire edges in clock cycles
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_ff  <= 1'b0;
            now_ff   <= '0;
            rise_ff  <= '0;
            o_period <= '0;
            o_high   <= '0;
        end else begin
            line_ff <= o_line;
            now_ff  <= now_ff + 32'h1;
            // Rising edge closes one period
            if (o_line === 1'b1 && line_ff === 1'b0) begin
                o_period <= now_ff - rise_ff;
                rise_ff  <= now_ff;
            end
            // Falling edge closes the high time
            if (o_line === 1'b0 && line_ff === 1'b1) begin
                o_high <= now_ff - rise_ff;
            end
        end
    end
endmodule

// ### verification/double_buffered_pwm_output_bench.sv
// Self-checking bench of the double buffered PWM output stage
`timescale 1ns/10ps
module double_buffered_pwm_output_bench;
    import dbp_pkg::*;
    // Row of the ordinary cases
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] per;
        logic [9:0] duty;
    } dbp_row_t;
    logic        sys_clk     = 1'b0;  // System clock
    logic        rst_n       = 1'b0;  // Reset, active low
    logic        clk_en      = 1'b1;  // Clock enable
    logic        ctrl_wr     = 1'b0;  // Control write strobe
    logic [7:0]  ctrl_data   = 8'h00; // Control data
    logic        duty_wr     = 1'b0;  // Duty write strobe
    logic [7:0]  duty_data   = 8'h00; // Duty data
    logic        period_wr   = 1'b0;  // Period write strobe
    logic [7:0]  period_data = 8'h00; // Period data
    logic        timer_on    = 1'b0;  // Timer run
    logic [1:0]  pre_sel     = 2'h0;  // Prescale select
    logic        port_dir    = 1'b0;  // 0 = pin driven
    logic        port_latch  = 1'b0;  // Port data latch
    logic        pin;                 // Pin value
    logic        pin_oe;              // Pin enable
    logic [7:0]  ctrl_rb;             // Control readback
    logic [7:0]  duty_rb;             // Duty buffer readback
    logic [7:0]  per_rb;              // Period readback
    logic [7:0]  tmr_rb;              // Timer readback
    logic [7:0]  act_rb;              // Active duty readback
    logic        line;                // Wire level
    logic [31:0] lm_per;              // Measured period
    logic [31:0] lm_high;             // Measured high time
    int          failures    = 0;     // Mismatch count
    int          n_tests     = 0;     // Comparison count
    int          cycles      = 0;     // Timeout counter
    int          h;                   // High cycles seen
    dbp_row_t    rows [7] = '{'{2'h0, 8'h00, 10'h002},
                              '{2'h0, 8'h03, 10'h005},
                              '{2'h1, 8'h01, 10'h007},
                              '{2'h2, 8'h00, 10'h001},
                              '{2'h0, 8'h02, 10'h00B},
                              '{2'h1, 8'h00, 10'h003},
                              '{2'h3, 8'h00, 10'h003}};

    // Clock at 25 MHz
    always #20 sys_clk = ~sys_clk;

    dbp_pwm_top i_dut (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
        .i_ctrl_wr(ctrl_wr), .i_ctrl_data(ctrl_data),
        .i_duty_wr(duty_wr), .i_duty_data(duty_data),
        .i_period_wr(period_wr), .i_period_data(period_data),
        .i_timer_on(timer_on), .i_prescale_sel(pre_sel),
        .i_shared_port_direction(port_dir),
        .i_shared_io_port_latch(port_latch),
        .o_pwm_output_pin(pin), .o_pwm_output_pin_oe(pin_oe),
        .o_compare_unit_control(ctrl_rb),
        .o_duty_buffer_register(duty_rb),
        .o_period_register(per_rb), .o_period_timer_count(tmr_rb),
        .o_active_duty_latch(act_rb));

    dbp_load_model i_load (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_pin(pin),
        .i_pin_oe(pin_oe), .o_line(line), .o_period(lm_per),
        .o_high(lm_high));

    // Prescale factor per select code
    function automatic int fac(input logic [1:0] s);
        return (s == 2'h0) ? 1 : ((s == 2'h1) ? 4 : 16);
    endfunction

    // Compares one value with its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One register write: 0 control, 1 period, 2 duty
    task automatic wr(input int k, input logic [7:0] d);
        ctrl_wr     = (k == 0);
        period_wr   = (k == 1);
        duty_wr     = (k == 2);
        ctrl_data   = d;
        period_data = d;
        duty_data   = d;
        @(negedge sys_clk);
        ctrl_wr   = 1'b0;
        period_wr = 1'b0;
        duty_wr   = 1'b0;
        @(negedge sys_clk);
    endtask

    // Runs n cycles watching the timer stay within the period
    task automatic run(input int n, input logic [7:0] p);
        repeat (n) begin
            @(negedge sys_clk);
            check(32'(tmr_rb <= p), 32'h1);
        end
    endtask

    // Counts high cycles of the wire over n cycles
    task automatic hold(input int n, output int hc);
        hc = 0;
        repeat (n) begin
            @(negedge sys_clk);
            if (line === 1'b1) hc++;
        end
    endtask

    // Reset for 8 cycles, then set up PWM with select, period, duty
    task automatic setup(input logic [1:0] s, input logic [7:0] p,
                         input logic [9:0] d);
        rst_n    = 1'b0;
        timer_on = 1'b0;
        repeat (8) @(negedge sys_clk);
        rst_n   = 1'b1;
        pre_sel = s;
        @(negedge sys_clk);
        wr(1, p);
        wr(2, d[9:2]);
        wr(0, {2'h0, d[1:0], 4'hC});
        timer_on = 1'b1;
    endtask

    // Cuts a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        // Ordinary cases: period and high time per row
        for (int r = 0; r < 7; r++) begin
            setup(rows[r].sel, rows[r].per, rows[r].duty);
            run(16 * (rows[r].per + 1) * fac(rows[r].sel) + 8, rows[r].per);
            check(32'(per_rb), 32'(rows[r].per));
            check({16'h0, duty_rb, ctrl_rb},
                  {16'h0, rows[r].duty[9:2], 2'h0, rows[r].duty[1:0], 4'hC});
            check(lm_per, (rows[r].per + 1) * 4 * fac(rows[r].sel));
            check(lm_high, rows[r].duty * fac(rows[r].sel));
        end
        // Reset values
        rst_n = 1'b0;
        @(negedge sys_clk);
        check({30'h0, pin, pin_oe}, 32'h0);
        check({8'h00, ctrl_rb, duty_rb, act_rb}, 32'h0);
        check({16'h0, per_rb, tmr_rb}, 32'h0000FF00);
        // Duty change mid period waits for the period end
        setup(2'h0, 8'h07, 10'h010);
        run(100, 8'h07);
        check(lm_high, 32'd16);
        h = 0;
        while (!(line === 1'b1) && h < 64) begin
            @(negedge sys_clk);
            h++;
        end
        wr(2, 8'h06);
        check(32'(act_rb), 32'h04);
        run(40, 8'h07);
        check(32'(act_rb), 32'h06);
        run(70, 8'h07);
        check(lm_high, 32'd24);
        // Duty beyond the period keeps the pin high
        wr(2, 8'h09);
        run(70, 8'h07);
        hold(64, h);
        check(32'(h), 32'd64);
        // Released pin: direction set means no drive
        port_dir = 1'b1;
        repeat (2) @(negedge sys_clk);
        check({31'h0, pin_oe}, 32'h0);
        check({31'h0, line}, 32'h0);
        port_dir = 1'b0;
        repeat (2) @(negedge sys_clk);
        check({31'h0, pin_oe}, 32'h1);
        // Clearing control drops the latch; port latch untouched
        wr(0, 8'h00);
        check({31'h0, pin}, 32'h0);
        port_latch = 1'b1;
        repeat (2) @(negedge sys_clk);
        check({31'h0, pin}, 32'h1);
        port_latch = 1'b0;
        // Zero duty never raises the pin
        wr(2, 8'h00);
        wr(0, 8'h0C);
        run(70, 8'h07);
        hold(64, h);
        check(32'(h), 32'd0);
        // Clock enable low freezes the timer, high lets it run on
        clk_en = 1'b0;
        h = int'(tmr_rb);
        repeat (9) @(negedge sys_clk);
        check(32'(tmr_rb), 32'(h));
        clk_en = 1'b1;
        repeat (9) @(negedge sys_clk);
        check(32'(tmr_rb != 8'(h)), 32'h1);
        finish_test();
    end
endmodule
